// File: rtl/mgcs_pkg.sv
// package of the memory controller global control and status block
// assumes one ahb-lite slave on hclk, 32-bit data, word transfers only
`default_nettype none
package mgcs_pkg;
   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] MGCS_CTRL_ADDR = 32'h8000_8000;
   localparam logic [31:0] MGCS_STAT_ADDR = 32'h8000_8004;
   localparam logic [31:0] MGCS_CFG_ADDR = 32'h8000_8008;
   // external chip select windows, 64 mbyte each
   localparam logic [31:0] MGCS_CS_MASK = 32'hfc00_0000;
   localparam logic [31:0] MGCS_CS0_BASE = 32'h2000_0000;
   localparam logic [31:0] MGCS_CS1_BASE = 32'h2400_0000;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MGCS_ON_BIT = 0;
   localparam int MGCS_MIRROR_BIT = 1;
   localparam int MGCS_LP_BIT = 2;
   localparam int MGCS_BUSY_BIT = 0;
   localparam int MGCS_WBUF_BIT = 1;
   localparam int MGCS_SRACK_BIT = 2;
   localparam int MGCS_BE_BIT = 0;
   localparam int MGCS_HALF_BIT = 8;
   localparam logic [31:0] MGCS_CTRL_WMASK = 32'h0000_0007;
   localparam logic [31:0] MGCS_CFG_SWMASK = 32'h0000_0001;
   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic MGCS_ON_RST = 1'b1;
   localparam logic MGCS_MIRROR_POR = 1'b1;
   localparam logic MGCS_LP_RST = 1'b0;
   localparam logic MGCS_SRACK_POR = 1'b1;
   localparam logic MGCS_BE_POR = 1'b0;
   localparam logic MGCS_HALF_POR = 1'b0;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int MGCS_CLK_NS = 5;
   localparam int MGCS_SR_HS_NS = 10;
   localparam int MGCS_SR_HS_CYC = (MGCS_SR_HS_NS + MGCS_CLK_NS - 1) / MGCS_CLK_NS;
   // ----------------------------------------------------------------
   // ahb codes
   // ----------------------------------------------------------------
   localparam logic [1:0] MGCS_HTRANS_IDLE = 2'h0;
   localparam logic [1:0] MGCS_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] MGCS_HSIZE_WORD = 3'h2;

   typedef enum {MGCS_K_CTRL, MGCS_K_STAT, MGCS_K_CFG, MGCS_K_EXT, MGCS_K_BAD} mgcs_kind_t;

   function automatic logic mgcs_in_cs(input logic [31:0] a, input logic [31:0] base);
      return (a & MGCS_CS_MASK) == base;
   endfunction
endpackage
`default_nettype wire

// File: rtl/mgcs_ahb_if.sv
// ahb-lite wires between the bus master end and the register bank end
// assumes a single slave, whose hreadyout is the bus hready
`timescale 1ns/1ps
`default_nettype none
interface mgcs_ahb_if (
   input wire logic hclk,
   input wire logic hresetn
);
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;

   modport slave (
      input hclk, hresetn, haddr, htrans, hwrite, hsize, hwdata,
      output hrdata, hready, hresp
   );
   modport master (
      input hclk, hresetn, hrdata, hready, hresp,
      output haddr, htrans, hwrite, hsize, hwdata
   );
endinterface
`default_nettype wire

// File: rtl/mgcs_device.sv
// register bank and access gate of the memory controller
// assumes hresetn is the power-on reset, warm_rst a synchronous pulse
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RQ1) enable set by resets, software writable
// (RQ2) software disables only while idle
// (RQ3) no refresh while disabled
// (RQ4) mirror bit routes chip select 0 to 1
// (RQ5) mirror clear keeps both selects independent
// (RQ6) low-power set while idle, refresh continues
// (RQ7) writing zero leaves low-power mode
// (RQ8) external access refused with error when off
// (RQ9) registers always reachable
// (RQ10) busy shows activity or self-refresh
// (RQ11) busy set at power-on via self-refresh
// (RQ12) write-buffer flag shows pending buffered data
// (RQ13) software waits for idle before reconfiguring
// (RQ14) self-refresh ack follows request after delay
// (RQ15) ack answers either request source
// (RQ16) configuration changed only when quiet
// (RQ17) configuration access takes one wait state
// (RQ18) endian bit selects big-endian ordering
// (RQ19) memory clock from hclk, halving unused
// (RQ20) software keeps reserved bits at zero
// (RQ21) reserved bits read zero, writes ignored
module mgcs_device
   import mgcs_pkg::*;
(
   mgcs_ahb_if.slave bus,
   input wire logic warm_rst,
   input wire logic mem_busy,
   input wire logic wbuf_pending,
   input wire logic sr_req_dyn,
   input wire logic sr_req_misc,
   output logic controller_on,
   output logic addr_mirror,
   output logic low_power,
   output logic refresh_enable,
   output logic big_endian,
   output logic memclk_halving,
   output logic sr_ack,
   output logic cs0_sel,
   output logic cs1_sel
);
   typedef enum {MGCS_S_IDLE, MGCS_S_DATA, MGCS_S_CFGW, MGCS_S_ERR1, MGCS_S_ERR2} mgcs_sst_t;

   mgcs_sst_t st_q, st_d;
   mgcs_kind_t kind_q, kind_d;
   logic write_q;
   logic on_q, mirror_q, lp_q, be_q, half_q, srack_q;
   logic cs0_q, cs1_q;
   logic [3:0] hs_cnt_q;
   logic accept, wr_now, sr_req, busy;

   // ----------------------------------------------------------------
   // address phase decode
   // ----------------------------------------------------------------
   assign accept = bus.htrans[1] & bus.hready;

   always_comb begin
      kind_d = MGCS_K_BAD;
      // register decode ignores enable and low-power state
      if (bus.haddr == MGCS_CTRL_ADDR) begin // RQ9
         kind_d = MGCS_K_CTRL;
      end else if (bus.haddr == MGCS_STAT_ADDR) begin
         kind_d = MGCS_K_STAT;
      end else if (bus.haddr == MGCS_CFG_ADDR) begin
         kind_d = MGCS_K_CFG;
      end else if (mgcs_in_cs(bus.haddr, MGCS_CS0_BASE) || mgcs_in_cs(bus.haddr, MGCS_CS1_BASE)) begin
         // memory is unreachable while off or in low power
         kind_d = (on_q && !lp_q) ? MGCS_K_EXT : MGCS_K_BAD; // RQ8
      end
   end

   // ----------------------------------------------------------------
   // data phase sequencing
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         MGCS_S_CFGW: st_d = MGCS_S_DATA; // RQ17
         MGCS_S_ERR1: st_d = MGCS_S_ERR2;
         MGCS_S_IDLE, MGCS_S_DATA, MGCS_S_ERR2: begin
            if (!accept) begin
               st_d = MGCS_S_IDLE;
            end else if (kind_d == MGCS_K_BAD) begin
               st_d = MGCS_S_ERR1; // RQ8
            end else if (kind_d == MGCS_K_CFG) begin
               st_d = MGCS_S_CFGW; // RQ17
            end else begin
               st_d = MGCS_S_DATA;
            end
         end
         default: st_d = MGCS_S_IDLE;
      endcase
   end

   always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
      if (!bus.hresetn) begin
         st_q <= MGCS_S_IDLE;
         kind_q <= MGCS_K_BAD;
         write_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (accept) begin
            kind_q <= kind_d;
            write_q <= bus.hwrite;
         end
      end
   end

   // two-cycle error response, one wait state on configuration
   assign bus.hready = (st_q != MGCS_S_CFGW) && (st_q != MGCS_S_ERR1); // RQ17
   assign bus.hresp = (st_q == MGCS_S_ERR1) || (st_q == MGCS_S_ERR2); // RQ8
   assign wr_now = (st_q == MGCS_S_DATA) && write_q;

   always_comb begin
      bus.hrdata = 32'h0000_0000; // RQ21
      case (kind_q)
         MGCS_K_CTRL: begin
            bus.hrdata[MGCS_ON_BIT] = on_q;
            bus.hrdata[MGCS_MIRROR_BIT] = mirror_q;
            bus.hrdata[MGCS_LP_BIT] = lp_q;
         end
         MGCS_K_STAT: begin
            bus.hrdata[MGCS_BUSY_BIT] = busy;
            bus.hrdata[MGCS_WBUF_BIT] = wbuf_pending; // RQ12
            bus.hrdata[MGCS_SRACK_BIT] = srack_q; // RQ14
         end
         MGCS_K_CFG: begin
            bus.hrdata[MGCS_BE_BIT] = be_q;
            bus.hrdata[MGCS_HALF_BIT] = half_q;
         end
         default: bus.hrdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
      if (!bus.hresetn) begin
         on_q <= MGCS_ON_RST; // RQ1
         lp_q <= MGCS_LP_RST; // RQ6
      end else if (warm_rst) begin
         on_q <= MGCS_ON_RST; // RQ1
         lp_q <= MGCS_LP_RST; // RQ6
      end else if (wr_now && kind_q == MGCS_K_CTRL) begin
         // idle is left to software; the bank does not delay the change
         on_q <= bus.hwdata[MGCS_ON_BIT]; // RQ1
         lp_q <= bus.hwdata[MGCS_LP_BIT]; // RQ7
      end
   end

   // mirror survives a warm reset so a reboot still finds its device
   always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
      if (!bus.hresetn) begin
         mirror_q <= MGCS_MIRROR_POR; // RQ4
      end else if (wr_now && kind_q == MGCS_K_CTRL) begin
         mirror_q <= bus.hwdata[MGCS_MIRROR_BIT]; // RQ5
      end
   end

   // ----------------------------------------------------------------
   // configuration register
   // ----------------------------------------------------------------
   always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
      if (!bus.hresetn) begin
         be_q <= MGCS_BE_POR;
         half_q <= MGCS_HALF_POR;
      end else if (wr_now && kind_q == MGCS_K_CFG) begin
         be_q <= bus.hwdata[MGCS_BE_BIT]; // RQ18
         half_q <= bus.hwdata[MGCS_HALF_BIT];
      end
   end

   // ----------------------------------------------------------------
   // self-refresh handshake
   // ----------------------------------------------------------------
   assign sr_req = sr_req_dyn | sr_req_misc; // RQ15

   // ack moves only after the request has differed for the full delay
   always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
      if (!bus.hresetn) begin
         srack_q <= MGCS_SRACK_POR; // RQ11
         hs_cnt_q <= 4'h0;
      end else if (sr_req == srack_q) begin
         hs_cnt_q <= 4'h0;
      end else if (hs_cnt_q == 4'(MGCS_SR_HS_CYC - 1)) begin
         srack_q <= sr_req; // RQ14
         hs_cnt_q <= 4'h0;
      end else begin
         hs_cnt_q <= hs_cnt_q + 4'h1;
      end
   end

   assign busy = mem_busy | srack_q; // RQ10

   // ----------------------------------------------------------------
   // chip select steering
   // ----------------------------------------------------------------
   always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
      if (!bus.hresetn) begin
         cs0_q <= 1'b0;
         cs1_q <= 1'b0;
      end else if (accept && kind_d == MGCS_K_EXT) begin
         cs0_q <= mgcs_in_cs(bus.haddr, MGCS_CS0_BASE) && !mirror_q; // RQ5
         cs1_q <= mgcs_in_cs(bus.haddr, MGCS_CS1_BASE) ||
                  (mgcs_in_cs(bus.haddr, MGCS_CS0_BASE) && mirror_q); // RQ4
      end else begin
         cs0_q <= 1'b0;
         cs1_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign controller_on = on_q;
   assign addr_mirror = mirror_q;
   assign low_power = lp_q;
   assign refresh_enable = on_q; // RQ3 RQ6
   assign big_endian = be_q;
   // halving is only reported; the memory clock stays on hclk
   assign memclk_halving = half_q; // RQ19
   assign sr_ack = srack_q;
   assign cs0_sel = cs0_q;
   assign cs1_sel = cs1_q;
endmodule // mgcs_device
`default_nettype wire

// File: rtl/mgcs_host.sv
// ahb-lite master that carries software orders to the register bank
// assumes the bank is the only slave; waits on hready without a limit
`timescale 1ns/1ps
`default_nettype none
module mgcs_host
   import mgcs_pkg::*;
(
   mgcs_ahb_if.master bus,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [31:0] cmd_addr,
   input wire logic [31:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [31:0] rsp_rdata,
   output logic rsp_err
);
   typedef enum {MGCS_H_IDLE, MGCS_H_ADDR, MGCS_H_DATA} mgcs_hst_t;

   mgcs_hst_t st_q;
   logic poll_q, op_write_q;
   logic [31:0] op_addr_q, op_wdata_q;
   logic guard;
   logic [31:0] clean;

   // ----------------------------------------------------------------
   // order screening
   // ----------------------------------------------------------------
   // disabling, entering low power and reconfiguring wait for quiet
   assign guard = cmd_write && ((cmd_addr == MGCS_CTRL_ADDR &&
                  (!cmd_wdata[MGCS_ON_BIT] || cmd_wdata[MGCS_LP_BIT])) ||
                  cmd_addr == MGCS_CFG_ADDR); // RQ2 RQ13 RQ16

   always_comb begin
      clean = cmd_wdata;
      if (cmd_addr == MGCS_CTRL_ADDR) begin
         clean = cmd_wdata & MGCS_CTRL_WMASK; // RQ20
      end else if (cmd_addr == MGCS_CFG_ADDR) begin
         // halving bit is never set from this side
         clean = cmd_wdata & MGCS_CFG_SWMASK; // RQ19 RQ20
      end
   end

   // ----------------------------------------------------------------
   // bus sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
      if (!bus.hresetn) begin
         st_q <= MGCS_H_IDLE;
         poll_q <= 1'b0;
         op_write_q <= 1'b0;
         op_addr_q <= 32'h0000_0000;
         op_wdata_q <= 32'h0000_0000;
         bus.haddr <= 32'h0000_0000;
         bus.htrans <= MGCS_HTRANS_IDLE;
         bus.hwrite <= 1'b0;
         bus.hwdata <= 32'h0000_0000;
      end else begin
         case (st_q)
            MGCS_H_IDLE: begin
               if (cmd_valid) begin
                  op_write_q <= cmd_write;
                  op_addr_q <= cmd_addr;
                  op_wdata_q <= clean;
                  poll_q <= guard;
                  bus.haddr <= guard ? MGCS_STAT_ADDR : cmd_addr;
                  bus.hwrite <= guard ? 1'b0 : cmd_write;
                  bus.htrans <= MGCS_HTRANS_NONSEQ;
                  st_q <= MGCS_H_ADDR;
               end
            end
            MGCS_H_ADDR: begin
               if (bus.hready) begin
                  bus.htrans <= MGCS_HTRANS_IDLE;
                  bus.hwdata <= poll_q ? 32'h0000_0000 : op_wdata_q;
                  st_q <= MGCS_H_DATA;
               end
            end
            MGCS_H_DATA: begin
               if (bus.hready) begin
                  if (poll_q) begin
                     // retry the status read until busy and buffer are clear
                     if (!bus.hrdata[MGCS_BUSY_BIT] && !bus.hrdata[MGCS_WBUF_BIT]) begin // RQ13
                        poll_q <= 1'b0;
                        bus.haddr <= op_addr_q;
                        bus.hwrite <= op_write_q;
                     end
                     bus.htrans <= MGCS_HTRANS_NONSEQ;
                     st_q <= MGCS_H_ADDR;
                  end else begin
                     st_q <= MGCS_H_IDLE;
                  end
               end
            end
            default: st_q <= MGCS_H_IDLE;
         endcase
      end
   end

   always_ff @(posedge bus.hclk or negedge bus.hresetn) begin
      if (!bus.hresetn) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 32'h0000_0000;
         rsp_err <= 1'b0;
      end else begin
         rsp_valid <= (st_q == MGCS_H_DATA) && bus.hready && !poll_q;
         if ((st_q == MGCS_H_DATA) && bus.hready && !poll_q) begin
            rsp_rdata <= bus.hrdata;
            rsp_err <= bus.hresp;
         end
      end
   end

   assign bus.hsize = MGCS_HSIZE_WORD;
   assign cmd_ready = (st_q == MGCS_H_IDLE);
endmodule // mgcs_host
`default_nettype wire

// File: dv/mgcs_ahb_sva.sv
// checker of the register bus between the host end and the register bank end
// assumes it is instantiated beside the interface, fed with its plain signals
`timescale 1ns/1ps
`default_nettype none
module mgcs_ahb_sva
   import mgcs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hready,
   input wire logic hresp
);
   // ----------------------------------------------------------------
   // data phase tracking
   // ----------------------------------------------------------------
   logic take;
   logic addr_ext;
   logic addr_reg;
   logic dp_q;
   logic dp_wr_q;
   logic [31:0] dp_addr_q;
   logic rd_end;
   assign take = htrans[1] && hready;
   assign addr_ext = ((haddr & MGCS_CS_MASK) == MGCS_CS0_BASE) || ((haddr & MGCS_CS_MASK) == MGCS_CS1_BASE);
   assign addr_reg = (haddr == MGCS_CTRL_ADDR) || (haddr == MGCS_STAT_ADDR) || (haddr == MGCS_CFG_ADDR);
   // read data only counts at the edge that closes a read data phase
   assign rd_end = dp_q && !dp_wr_q && hready;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_q <= 1'b0;
         dp_wr_q <= 1'b0;
         dp_addr_q <= 32'h0;
      end else if (hready) begin
         dp_q <= htrans[1];
         dp_wr_q <= hwrite;
         dp_addr_q <= haddr;
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_ok_now;
      hready && !hresp;
   endsequence
   sequence s_wait_one;
      (!hready && !hresp) ##1 (hready && !hresp);
   endsequence
   sequence s_err_pair;
      (!hready && hresp) ##1 (hready && hresp);
   endsequence
   a_cfg_one_wait: assert property (take && haddr == MGCS_CFG_ADDR |=> s_wait_one)
      else $error("configuration access without exactly one wait state");
   a_reg_no_wait: assert property (take && (haddr == MGCS_CTRL_ADDR || haddr == MGCS_STAT_ADDR) |=> s_ok_now)
      else $error("control or status access not answered at once");
   a_ext_answer: assert property (take && addr_ext |=> s_ok_now or s_err_pair)
      else $error("external access answer malformed");
   a_bad_addr_err: assert property (take && !addr_ext && !addr_reg |=> s_err_pair)
      else $error("unmapped access not refused with two-cycle error");
   a_idle_okay: assert property (!dp_q |-> s_ok_now)
      else $error("slave not ready or erroring outside a data phase");
   a_ctrl_rsv_zero: assert property (rd_end && dp_addr_q == MGCS_CTRL_ADDR |-> hrdata[31:3] == 29'h0)
      else $error("control reserved bits read nonzero");
   a_stat_rsv_zero: assert property (rd_end && dp_addr_q == MGCS_STAT_ADDR |-> hrdata[31:3] == 29'h0)
      else $error("status reserved bits read nonzero");
   a_cfg_rsv_zero: assert property (rd_end && dp_addr_q == MGCS_CFG_ADDR |-> hrdata[31:9] == 23'h0 && hrdata[7:1] == 7'h0)
      else $error("configuration reserved bits read nonzero");
   a_word_size: assert property (htrans[1] |-> hsize == MGCS_HSIZE_WORD && haddr[1:0] == 2'h0)
      else $error("transfer size is not a word");
   a_no_halving: assert property (dp_q && dp_wr_q && dp_addr_q == MGCS_CFG_ADDR |-> !hwdata[MGCS_HALF_BIT])
      else $error("clock halving bit written as one");
endmodule // mgcs_ahb_sva
`default_nettype wire

// File: dv/memctl_global_control_status_tb_top.sv
// testbench joining host end and register bank end over the bus interface
// assumes the package and both design ends are compiled first
`timescale 1ns/1ps
`default_nettype none
module memctl_global_control_status_tb_top
   import mgcs_pkg::*;
();
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic hclk;
   logic hresetn;
   logic warm_rst, mem_busy, wbuf_pending, sr_req_dyn, sr_req_misc;
   logic controller_on, addr_mirror, low_power, refresh_enable, big_endian, memclk_halving, sr_ack, cs0_sel, cs1_sel;
   logic cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_err;
   logic [31:0] cmd_addr, cmd_wdata, rsp_rdata;
   int n_fail, checks_done, n_cs0, n_cs1;
   mgcs_ahb_if i_mgcs_ahb_if (.hclk(hclk), .hresetn(hresetn));
   mgcs_device i_mgcs_device (.bus(i_mgcs_ahb_if), .warm_rst(warm_rst), .mem_busy(mem_busy),
      .wbuf_pending(wbuf_pending), .sr_req_dyn(sr_req_dyn), .sr_req_misc(sr_req_misc),
      .controller_on(controller_on), .addr_mirror(addr_mirror), .low_power(low_power),
      .refresh_enable(refresh_enable), .big_endian(big_endian), .memclk_halving(memclk_halving),
      .sr_ack(sr_ack), .cs0_sel(cs0_sel), .cs1_sel(cs1_sel));
   mgcs_host i_mgcs_host (.bus(i_mgcs_ahb_if), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_err(rsp_err));
   mgcs_ahb_sva i_mgcs_ahb_sva (.hclk(hclk), .hresetn(hresetn), .haddr(i_mgcs_ahb_if.haddr),
      .htrans(i_mgcs_ahb_if.htrans), .hwrite(i_mgcs_ahb_if.hwrite), .hsize(i_mgcs_ahb_if.hsize),
      .hwdata(i_mgcs_ahb_if.hwdata), .hrdata(i_mgcs_ahb_if.hrdata), .hready(i_mgcs_ahb_if.hready),
      .hresp(i_mgcs_ahb_if.hresp));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // chip select pulses last one cycle, so count them rather than poll
   always @(posedge hclk) begin
      if (cs0_sel === 1'b1) n_cs0++;
      if (cs1_sel === 1'b1) n_cs1++;
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pin(input string what, input logic seen, input logic exp);
      chk(what, {31'h0, seen}, {31'h0, exp});
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // guarded writes poll status inside the host, hence the generous bound
   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
      int i;
      @(posedge hclk);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_addr <= addr;
      cmd_wdata <= wdata;
      @(posedge hclk);
      cmd_valid <= 1'b0;
      for (i = 0; i < 400; i++) begin
         @(posedge hclk);
         #1;
         if (rsp_valid === 1'b1) break;
      end
      if (i == 400) begin
         n_fail++;
         wrap_up();
      end
      rdata = rsp_rdata;
      err = rsp_err;
   endtask
   task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input logic exp_err, input string what);
      logic [31:0] d;
      logic e;
      bus(1'b0, addr, 32'h0, d, e);
      pin({what, " error"}, e, exp_err);
      if (!exp_err) chk(what, d, exp);
   endtask
   task automatic wr(input logic [31:0] addr, input logic [31:0] data, input string what);
      logic [31:0] d;
      logic e;
      bus(1'b1, addr, data, d, e);
      pin({what, " error"}, e, 1'b0);
   endtask
   task automatic ext(input logic [31:0] addr, input logic exp_err, input int d0, input int d1);
      int c0;
      int c1;
      c0 = n_cs0;
      c1 = n_cs1;
      rd(addr, 32'h0, exp_err, "external read");
      chk("cs0 pulses", n_cs0 - c0, d0);
      chk("cs1 pulses", n_cs1 - c1, d1);
   endtask
   // a guarded write must stall while status shows activity, then land once it clears
   task automatic held(input logic [31:0] addr, input logic [31:0] data, input logic use_wbuf);
      fork
         wr(addr, data, "guarded write");
         begin
            repeat (20) @(posedge hclk);
            #1;
            pin("cmd_ready while busy", cmd_ready, 1'b0);
            @(posedge hclk);
            if (use_wbuf) wbuf_pending <= 1'b0;
            else mem_busy <= 1'b0;
         end
      join
   endtask
   task automatic sr_step(input logic dyn, input logic misc, input logic exp);
      @(posedge hclk);
      sr_req_dyn <= dyn;
      sr_req_misc <= misc;
      @(posedge hclk);
      #1;
      pin("sr_ack before handshake", sr_ack, ~exp);
      @(posedge hclk);
      #1;
      pin("sr_ack after handshake", sr_ack, exp);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {hresetn, warm_rst, mem_busy, wbuf_pending, sr_req_misc, cmd_valid, cmd_write} = 7'h0;
      sr_req_dyn = 1'b1;
      cmd_addr = 32'h0;
      cmd_wdata = 32'h0;
      {n_fail, checks_done, n_cs0, n_cs1} = {32'h0, 32'h0, 32'h0, 32'h0};
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      pin("controller_on", controller_on, 1'b1);
      pin("addr_mirror", addr_mirror, 1'b1);
      pin("low_power", low_power, 1'b0);
      pin("refresh_enable", refresh_enable, 1'b1);
      pin("sr_ack", sr_ack, 1'b1);
      pin("memclk_halving", memclk_halving, 1'b0);
      rd(MGCS_CTRL_ADDR, 32'h3, 1'b0, "control");
      rd(MGCS_STAT_ADDR, 32'h5, 1'b0, "status");
      rd(MGCS_CFG_ADDR, 32'h0, 1'b0, "configuration");
      sr_step(1'b0, 1'b0, 1'b0);
      rd(MGCS_STAT_ADDR, 32'h0, 1'b0, "status");
      @(posedge hclk);
      sr_req_misc <= 1'b1;
      @(posedge hclk);
      sr_req_misc <= 1'b0;
      repeat (2) @(posedge hclk);
      #1;
      pin("sr_ack after glitch", sr_ack, 1'b0);
      sr_step(1'b0, 1'b1, 1'b1);
      rd(MGCS_STAT_ADDR, 32'h5, 1'b0, "status");
      sr_step(1'b0, 1'b0, 1'b0);
      sr_step(1'b1, 1'b0, 1'b1);
      sr_step(1'b0, 1'b0, 1'b0);
      mem_busy <= 1'b1;
      rd(MGCS_STAT_ADDR, 32'h1, 1'b0, "status");
      mem_busy <= 1'b0;
      wbuf_pending <= 1'b1;
      rd(MGCS_STAT_ADDR, 32'h2, 1'b0, "status");
      wbuf_pending <= 1'b0;
      ext(MGCS_CS0_BASE, 1'b0, 0, 1);
      wr(MGCS_CTRL_ADDR, 32'h1, "control");
      ext(MGCS_CS0_BASE + 32'h10, 1'b0, 1, 0);
      ext(MGCS_CS1_BASE + 32'h4, 1'b0, 0, 1);
      wr(MGCS_CTRL_ADDR, 32'h5, "control");
      pin("low_power", low_power, 1'b1);
      pin("refresh_enable", refresh_enable, 1'b1);
      ext(MGCS_CS1_BASE, 1'b1, 0, 0);
      rd(MGCS_CTRL_ADDR, 32'h5, 1'b0, "control");
      wr(MGCS_CTRL_ADDR, 32'h1, "control");
      pin("low_power", low_power, 1'b0);
      ext(MGCS_CS1_BASE, 1'b0, 0, 1);
      wr(MGCS_CTRL_ADDR, 32'h0, "control");
      pin("controller_on", controller_on, 1'b0);
      pin("refresh_enable", refresh_enable, 1'b0);
      ext(MGCS_CS0_BASE, 1'b1, 0, 0);
      wbuf_pending <= 1'b1;
      held(MGCS_CFG_ADDR, 32'hffff_ffff, 1'b1);
      rd(MGCS_CFG_ADDR, 32'h1, 1'b0, "configuration");
      pin("big_endian", big_endian, 1'b1);
      pin("memclk_halving", memclk_halving, 1'b0);
      wr(MGCS_CTRL_ADDR, 32'hffff_fff9, "control");
      rd(MGCS_CTRL_ADDR, 32'h1, 1'b0, "control");
      wr(MGCS_STAT_ADDR, 32'hffff_ffff, "status");
      rd(MGCS_STAT_ADDR, 32'h0, 1'b0, "status");
      rd(32'h8000_8010, 32'h0, 1'b1, "unmapped");
      mem_busy <= 1'b1;
      held(MGCS_CTRL_ADDR, 32'h4, 1'b0);
      pin("low_power", low_power, 1'b1);
      @(posedge hclk);
      warm_rst <= 1'b1;
      @(posedge hclk);
      warm_rst <= 1'b0;
      #1;
      pin("controller_on", controller_on, 1'b1);
      pin("low_power", low_power, 1'b0);
      pin("addr_mirror", addr_mirror, 1'b0);
      rd(MGCS_STAT_ADDR, 32'h0, 1'b0, "status");
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd(MGCS_CTRL_ADDR, 32'h3, 1'b0, "control");
      rd(MGCS_CFG_ADDR, 32'h0, 1'b0, "configuration");
      wrap_up();
   end
endmodule // memctl_global_control_status_tb_top
`default_nettype wire
